// ### swr_top.sv
// supervisor reset generator with basic and windowed watchdog.
// assumes asynchronous pins, AXI4-Lite master on REF_CLK_IN.
//
// Overview of operation
// - after all conditions clear, output stays low for hold time, then high
// - any watchdog fault produces a reset pulse of hold time
// - basic: counter cleared on each kick transition and while reset asserted
// - basic: zero period setting disables the watchdog entirely
// - extended mode multiplies basic timeout by 128
// - windowed: fault on kicks closer than fast limit or none by slow limit
// - windowed: counter starts only after the reset output is released
// - windowed: valid kick restarts counter; counter cleared while reset asserted
// - windowed: two straps choose the window ratio or disable watchdog
// - windowed: low strap high with high strap low disables watchdog
// - ratio slow/fast: both low 8, high strap alone 16, both high 64
// - windowed: kicks ignored while reset output asserted
// - range select low normal, high extended; any change clears counter
module swr_top #(
    parameter logic [31:0] HOLD_RST = 32'(swr_pkg::HOLD_CYC),
    parameter logic [31:0] BASIC_RST = 32'(swr_pkg::BASIC_PERIOD_CYC),
    parameter logic [31:0] SLOW_RST = 32'(swr_pkg::SLOW_LIMIT_CYC)
) (
    input wire logic REF_CLK_IN,
    input wire logic RST_IN,
    input wire logic WDOG_KICK_IN,
    input wire logic MANUAL_RESET_N_IN,
    input wire logic SUPPLY_UV_IN,
    input wire logic AUX_UV_IN,
    input wire logic WDOG_RANGE_SEL_IN,
    input wire logic WINDOW_SEL_LO_IN,
    input wire logic WINDOW_SEL_HI_IN,
    output logic SUPERVISOR_OUT_N_OUT,
    output logic IRQ_OUT,
    input wire logic [7:0] S_AXI_AWADDR_IN,
    input wire logic S_AXI_AWVALID_IN,
    output logic S_AXI_AWREADY_OUT,
    input wire logic [31:0] S_AXI_WDATA_IN,
    input wire logic [3:0] S_AXI_WSTRB_IN,
    input wire logic S_AXI_WVALID_IN,
    output logic S_AXI_WREADY_OUT,
    output logic [1:0] S_AXI_BRESP_OUT,
    output logic S_AXI_BVALID_OUT,
    input wire logic S_AXI_BREADY_IN,
    input wire logic [7:0] S_AXI_ARADDR_IN,
    input wire logic S_AXI_ARVALID_IN,
    output logic S_AXI_ARREADY_OUT,
    output logic [31:0] S_AXI_RDATA_OUT,
    output logic [1:0] S_AXI_RRESP_OUT,
    output logic S_AXI_RVALID_OUT,
    input wire logic S_AXI_RREADY_IN
);
    import swr_pkg::*;

    // ========================================================
    // pin synchronisers
    logic [SYNC_W-1:0] pins_s;
    wire kick_s = pins_s[6];
    wire mr_n_s = pins_s[5];
    wire sup_uv_s = pins_s[4];
    wire aux_uv_s = pins_s[3];
    wire range_s = pins_s[2];
    wire sel_lo_s = pins_s[1];
    wire sel_hi_s = pins_s[0];

    swr_sync #(
        .W(SYNC_W)
    ) u_sync (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .d_in({WDOG_KICK_IN, MANUAL_RESET_N_IN, SUPPLY_UV_IN, AUX_UV_IN,
               WDOG_RANGE_SEL_IN, WINDOW_SEL_LO_IN, WINDOW_SEL_HI_IN}),
        .q_out(pins_s)
    );

    // ========================================================
    // register bus
    swr_reg_if rif ();

    swr_axil u_axil (
        .clk_in(REF_CLK_IN),
        .rst_in(RST_IN),
        .awaddr_in(S_AXI_AWADDR_IN),
        .awvalid_in(S_AXI_AWVALID_IN),
        .awready_out(S_AXI_AWREADY_OUT),
        .wdata_in(S_AXI_WDATA_IN),
        .wstrb_in(S_AXI_WSTRB_IN),
        .wvalid_in(S_AXI_WVALID_IN),
        .wready_out(S_AXI_WREADY_OUT),
        .bresp_out(S_AXI_BRESP_OUT),
        .bvalid_out(S_AXI_BVALID_OUT),
        .bready_in(S_AXI_BREADY_IN),
        .araddr_in(S_AXI_ARADDR_IN),
        .arvalid_in(S_AXI_ARVALID_IN),
        .arready_out(S_AXI_ARREADY_OUT),
        .rdata_out(S_AXI_RDATA_OUT),
        .rresp_out(S_AXI_RRESP_OUT),
        .rvalid_out(S_AXI_RVALID_OUT),
        .rready_in(S_AXI_RREADY_IN),
        .rif(rif.bus)
    );

    // ========================================================
    // state
    logic win_q;
    logic [31:0] basic_period_q;
    logic [31:0] slow_limit_q;
    logic [31:0] hold_q;
    logic [IRQ_W-1:0] status_q;
    logic [IRQ_W-1:0] mask_q;
    logic out_n_q;
    logic irq_q;
    logic [31:0] hold_cnt_q;
    logic [CNT_W-1:0] wd_cnt_q;
    logic kick_prev_q;
    logic range_prev_q;
    logic lo_prev_q;
    logic hi_prev_q;
    logic cond_prev_q;

    // ========================================================
    // register decode
    wire wr_ctrl = rif.wr_en & (rif.wr_addr == ADDR_CTRL);
    wire wr_basic = rif.wr_en & (rif.wr_addr == ADDR_BASIC_PERIOD);
    wire wr_slow = rif.wr_en & (rif.wr_addr == ADDR_SLOW_LIMIT);
    wire wr_hold = rif.wr_en & (rif.wr_addr == ADDR_HOLD_TIME);
    wire wr_stat = rif.wr_en & (rif.wr_addr == ADDR_IRQ_STATUS);
    wire wr_mask = rif.wr_en & (rif.wr_addr == ADDR_IRQ_MASK);
    wire wr_ro = (rif.wr_addr == ADDR_STATE) | (rif.wr_addr == ADDR_WD_COUNT);
    assign rif.wr_err = ~(wr_ctrl | wr_basic | wr_slow | wr_hold | wr_stat | wr_mask | wr_ro);

    wire [31:0] wmerge_basic = (basic_period_q & ~rif.wr_mask) | (rif.wr_data & rif.wr_mask);
    wire [31:0] wmerge_slow = (slow_limit_q & ~rif.wr_mask) | (rif.wr_data & rif.wr_mask);
    wire [31:0] wmerge_hold = (hold_q & ~rif.wr_mask) | (rif.wr_data & rif.wr_mask);
    wire [31:0] wbits = rif.wr_data & rif.wr_mask;

    // ========================================================
    // reset conditions and hold pulse
    wire cond = sup_uv_s | aux_uv_s | ~mr_n_s;
    wire [31:0] hold_eff = (hold_q == 32'h0) ? 32'h1 : hold_q;
    wire hold_done = hold_cnt_q >= hold_eff - 32'h1;

    // ========================================================
    // watchdog decode
    wire kick_fall = kick_prev_q & ~kick_s;
    wire kick_tog = kick_prev_q ^ kick_s;
    // any strap or range change restarts timing, as does any control write
    wire cfg_chg = (range_s ^ range_prev_q) | (sel_lo_s ^ lo_prev_q) | (sel_hi_s ^ hi_prev_q) | wr_ctrl;
    wire basic_en = ~win_q & (basic_period_q != 32'h0);
    wire win_off = sel_lo_s & ~sel_hi_s;
    wire win_en = win_q & ~win_off & (slow_limit_q != 32'h0);
    wire wd_en = basic_en | win_en;
    wire [CNT_W-1:0] basic_lim = range_s ?
        (CNT_W'(basic_period_q) << EXT_SHIFT) : CNT_W'(basic_period_q);
    wire [2:0] ratio_shift = ~sel_hi_s ? SHIFT_RATIO_8 :
                             (sel_lo_s ? SHIFT_RATIO_64 : SHIFT_RATIO_16);
    wire [CNT_W-1:0] slow_lim = CNT_W'(slow_limit_q);
    wire [CNT_W-1:0] fast_lim = slow_lim >> ratio_shift;

    // faults only while released, so kicks under reset are ignored
    wire basic_fault = basic_en & out_n_q & ~kick_tog & (wd_cnt_q >= basic_lim);
    wire early_fault = win_en & out_n_q & kick_fall & (wd_cnt_q < fast_lim);
    wire late_fault = win_en & out_n_q & (wd_cnt_q >= slow_lim);
    wire fault = basic_fault | early_fault | late_fault;
    wire good_kick = (basic_en & kick_tog) | (win_en & kick_fall & out_n_q);
    wire wd_clr = ~out_n_q | ~wd_en | cfg_chg | fault | good_kick;

    // ========================================================
    // next values
    wire out_n_d = (cond | fault) ? 1'b0 :
                   ((~out_n_q & hold_done) ? 1'b1 : out_n_q);
    wire [31:0] hold_cnt_d = (cond | fault | out_n_q) ? 32'h0 : hold_cnt_q + 32'h1;
    wire [CNT_W-1:0] wd_cnt_d = wd_clr ? '0 : wd_cnt_q + CNT_W'(1);
    wire [IRQ_W-1:0] events = {cond & ~cond_prev_q, late_fault, early_fault, basic_fault};
    // a new event beats a same-cycle clear
    wire [IRQ_W-1:0] status_d = (status_q & ~(wr_stat ? wbits[IRQ_W-1:0] : '0)) | events;

    // ========================================================
    // register read mux
    assign rif.rd_err = ~((rif.rd_addr == ADDR_CTRL) | (rif.rd_addr == ADDR_BASIC_PERIOD) |
                          (rif.rd_addr == ADDR_SLOW_LIMIT) | (rif.rd_addr == ADDR_HOLD_TIME) |
                          (rif.rd_addr == ADDR_IRQ_STATUS) | (rif.rd_addr == ADDR_IRQ_MASK) |
                          (rif.rd_addr == ADDR_STATE) | (rif.rd_addr == ADDR_WD_COUNT));
    wire [31:0] state_word = {26'h0, sel_hi_s, sel_lo_s, range_s, win_en, basic_en, out_n_q};
    assign rif.rd_data =
        (rif.rd_addr == ADDR_CTRL) ? {31'h0, win_q} :
        (rif.rd_addr == ADDR_BASIC_PERIOD) ? basic_period_q :
        (rif.rd_addr == ADDR_SLOW_LIMIT) ? slow_limit_q :
        (rif.rd_addr == ADDR_HOLD_TIME) ? hold_q :
        (rif.rd_addr == ADDR_IRQ_STATUS) ? {28'h0, status_q} :
        (rif.rd_addr == ADDR_IRQ_MASK) ? {28'h0, mask_q} :
        (rif.rd_addr == ADDR_STATE) ? state_word :
        (rif.rd_addr == ADDR_WD_COUNT) ? wd_cnt_q[31:0] : 32'h0;

    // ========================================================
    // configuration registers
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            win_q <= CTRL_RST;
            basic_period_q <= BASIC_RST;
            slow_limit_q <= SLOW_RST;
            hold_q <= HOLD_RST;
            mask_q <= MASK_RST;
        end else begin
            if (wr_ctrl && rif.wr_mask[0]) begin
                win_q <= rif.wr_data[CTRL_WINDOWED_BIT];
            end
            if (wr_basic) begin
                basic_period_q <= wmerge_basic;
            end
            if (wr_slow) begin
                slow_limit_q <= wmerge_slow;
            end
            if (wr_hold) begin
                hold_q <= wmerge_hold;
            end
            if (wr_mask && rif.wr_mask[0]) begin
                mask_q <= rif.wr_data[IRQ_W-1:0];
            end
        end
    end

    // ========================================================
    // supervisor and watchdog state
    always_ff @(posedge REF_CLK_IN) begin
        if (RST_IN) begin
            out_n_q <= 1'b0;
            hold_cnt_q <= 32'h0;
            wd_cnt_q <= '0;
            kick_prev_q <= 1'b0;
            range_prev_q <= 1'b0;
            lo_prev_q <= 1'b0;
            hi_prev_q <= 1'b0;
            // synced manual reset reads low just after reset; no false condition event
            cond_prev_q <= 1'b1;
            status_q <= '0;
            irq_q <= 1'b0;
        end else begin
            out_n_q <= out_n_d;
            hold_cnt_q <= hold_cnt_d;
            wd_cnt_q <= wd_cnt_d;
            kick_prev_q <= kick_s;
            range_prev_q <= range_s;
            lo_prev_q <= sel_lo_s;
            hi_prev_q <= sel_hi_s;
            cond_prev_q <= cond;
            status_q <= status_d;
            irq_q <= |(status_q & mask_q);
        end
    end

    assign SUPERVISOR_OUT_N_OUT = out_n_q;
    assign IRQ_OUT = irq_q;

    // ========================================================
    // checks
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (RST_IN);

    property p_cond_low;
        cond |=> !out_n_q;
    endproperty
    a_cond_low: assert property (p_cond_low) else $error("reset output high during a condition");

    property p_hold_len;
        $rose(out_n_q) |-> $past(hold_cnt_q) >= $past(hold_eff) - 32'h1 && !$past(cond);
    endproperty
    a_hold_len: assert property (p_hold_len) else $error("reset released before hold time");

    property p_fault_pulse;
        fault |=> !out_n_q ##1 (!out_n_q || hold_eff <= 32'h1);
    endproperty
    a_fault_pulse: assert property (p_fault_pulse) else $error("fault did not start reset pulse");

    property p_basic_bound;
        basic_en && out_n_q |-> wd_cnt_q <= basic_lim;
    endproperty
    a_basic_bound: assert property (p_basic_bound) else $error("basic counter passed its limit");

    property p_clear_in_reset;
        !out_n_q |=> wd_cnt_q == '0;
    endproperty
    a_clear_in_reset: assert property (p_clear_in_reset) else $error("counter ran under reset");

    property p_disabled_idle;
        !wd_en |=> wd_cnt_q == '0 && !$past(fault);
    endproperty
    a_disabled_idle: assert property (p_disabled_idle) else $error("disabled watchdog counted");

    property p_range_clear;
        range_s != range_prev_q |=> wd_cnt_q == '0;
    endproperty
    a_range_clear: assert property (p_range_clear) else $error("range change kept count");

    property p_early;
        win_en && out_n_q && kick_fall && wd_cnt_q < fast_lim |-> early_fault ##1 !out_n_q;
    endproperty
    a_early: assert property (p_early) else $error("early kick not faulted");

    property p_ignore_kicks;
        !out_n_q |-> !early_fault && !late_fault && !basic_fault;
    endproperty
    a_ignore_kicks: assert property (p_ignore_kicks) else $error("fault raised under reset");

endmodule : swr_top

// ### swr_pkg.sv
// constants for the supervisor / watchdog reset block.
// assumes a single 50 MHz clock and an AXI4-Lite register port.
package swr_pkg;

    // ========================================================
    // clock and timing
    localparam int CLK_MHZ = 50;
    localparam int HOLD_TIME_US = 200;
    localparam int BASIC_PERIOD_US = 1000;
    localparam int SLOW_LIMIT_US = 10000;
    localparam int HOLD_CYC = HOLD_TIME_US * CLK_MHZ;
    localparam int BASIC_PERIOD_CYC = BASIC_PERIOD_US * CLK_MHZ;
    localparam int SLOW_LIMIT_CYC = SLOW_LIMIT_US * CLK_MHZ;
    localparam int CNT_W = 40;
    localparam int EXT_SHIFT = 7;

    // ========================================================
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_BASIC_PERIOD = 8'h04;
    localparam logic [7:0] ADDR_SLOW_LIMIT = 8'h08;
    localparam logic [7:0] ADDR_HOLD_TIME = 8'h0c;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
    localparam logic [7:0] ADDR_STATE = 8'h18;
    localparam logic [7:0] ADDR_WD_COUNT = 8'h1c;

    // ========================================================
    // fields and reset values
    localparam int CTRL_WINDOWED_BIT = 0;
    localparam int IRQ_W = 4;
    localparam int EV_BASIC_BIT = 0;
    localparam int EV_EARLY_BIT = 1;
    localparam int EV_LATE_BIT = 2;
    localparam int EV_COND_BIT = 3;
    localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
    localparam logic CTRL_RST = 1'b0;
    localparam int SYNC_W = 7;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // window ratio as a right shift of the slow limit
    localparam logic [2:0] SHIFT_RATIO_8 = 3'h3;
    localparam logic [2:0] SHIFT_RATIO_16 = 3'h4;
    localparam logic [2:0] SHIFT_RATIO_64 = 3'h6;

endpackage : swr_pkg

// ### swr_reg_if.sv
// register access carrier between the bus slave and the core.
// assumes both ends share one clock.
interface swr_reg_if;
    logic wr_en;
    logic [7:0] wr_addr;
    logic [31:0] wr_data;
    logic [31:0] wr_mask;
    logic wr_err;
    logic [7:0] rd_addr;
    logic [31:0] rd_data;
    logic rd_err;
    modport bus (output wr_en, wr_addr, wr_data, wr_mask, rd_addr,
                 input wr_err, rd_data, rd_err);
    modport regs (input wr_en, wr_addr, wr_data, wr_mask, rd_addr,
                  output wr_err, rd_data, rd_err);
endinterface : swr_reg_if

// ### swr_sync.sv
// two-flop synchroniser, one per bit.
// assumes inputs are asynchronous to clk_in.
module swr_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);
    logic [W-1:0] meta_q;

    // ========================================================
    // per-bit flop pairs
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge clk_in) begin
            if (rst_in) begin
                meta_q[i] <= 1'b0;
                q_out[i] <= 1'b0;
            end else begin
                meta_q[i] <= d_in[i];
                q_out[i] <= meta_q[i];
            end
        end
    end
endmodule : swr_sync

// ### swr_axil.sv
// AXI4-Lite slave front end for the supervisor registers.
// assumes one outstanding write and one outstanding read.
module swr_axil (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic [7:0] awaddr_in,
    input wire logic awvalid_in,
    output logic awready_out,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wstrb_in,
    input wire logic wvalid_in,
    output logic wready_out,
    output logic [1:0] bresp_out,
    output logic bvalid_out,
    input wire logic bready_in,
    input wire logic [7:0] araddr_in,
    input wire logic arvalid_in,
    output logic arready_out,
    output logic [31:0] rdata_out,
    output logic [1:0] rresp_out,
    output logic rvalid_out,
    input wire logic rready_in,
    swr_reg_if.bus rif
);
    import swr_pkg::*;
    logic aw_have_q;
    logic w_have_q;
    logic [7:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    wire aw_take = awvalid_in & awready_out;
    wire w_take = wvalid_in & wready_out;
    wire ar_take = arvalid_in & arready_out;
    wire wr_fire = aw_have_q & w_have_q & ~bvalid_out;

    assign awready_out = ~aw_have_q;
    assign wready_out = ~w_have_q;
    assign arready_out = ~rvalid_out;
    assign rif.wr_en = wr_fire;
    assign rif.wr_addr = aw_addr_q;
    assign rif.wr_data = w_data_q;
    assign rif.rd_addr = araddr_in;
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign rif.wr_mask[8*b +: 8] = {8{w_strb_q[b]}};
    end

    // ========================================================
    // write path: address and data in either order
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            bvalid_out <= 1'b0;
            bresp_out <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_have_q <= 1'b1;
                aw_addr_q <= awaddr_in;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                w_data_q <= wdata_in;
                w_strb_q <= wstrb_in;
            end
            if (wr_fire) begin
                bvalid_out <= 1'b1;
                bresp_out <= rif.wr_err ? RESP_SLVERR : RESP_OKAY;
            end else if (bvalid_out && bready_in) begin
                bvalid_out <= 1'b0;
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
            end
        end
    end

    // ========================================================
    // read path: data sampled at the address handshake
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            rvalid_out <= 1'b0;
            rdata_out <= 32'h0;
            rresp_out <= RESP_OKAY;
        end else if (ar_take) begin
            rvalid_out <= 1'b1;
            rdata_out <= rif.rd_data;
            rresp_out <= rif.rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rready_in) begin
            rvalid_out <= 1'b0;
        end
    end
endmodule : swr_axil

// ### swr_cpu_model.sv
// processor model: falling edge on the kick line once per set period.
// assumes it shares the bench clock and sits behind the active-low reset.
module swr_cpu_model (
    input wire logic clk_in,
    input wire logic reset_n_in,
    input wire logic en_in,
    input wire logic [15:0] period_in,
    output logic kick_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt_q;
    initial kick_out = 1'h0;
    // ========================================================
    // kick generator
    // a processor held in reset runs no code, so the count restarts on release
    always @(posedge clk_in) begin
        if (!reset_n_in || !en_in) begin
            cnt_q <= 16'h0;
            kick_out <= 1'h0; // idle line rests low, as with a pull-down
        end else begin
            cnt_q <= (cnt_q + 16'h1 >= period_in) ? 16'h0 : cnt_q + 16'h1;
            kick_out <= (cnt_q + 16'h2 >= period_in); // one falling edge each period
        end
    end
endmodule : swr_cpu_model

// ### swr_tb.sv
// self-checking bench: bus tasks, reset conditions, basic and windowed watchdog.
// assumes swr_pkg, the design and swr_cpu_model are compiled first.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import swr_pkg::*;
    localparam int HOLD = 20;
    localparam int SLOW = 400;
    logic clk, rst, kick, mr_n, uv, aux, rng, slo, shi, out_n, irq, en;
    logic [15:0] per;
    logic [7:0] awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, r;
    logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    int n_fail, checks_done, low_cnt, n;
    logic [7:0] ra [5] = '{ADDR_CTRL, ADDR_BASIC_PERIOD, ADDR_SLOW_LIMIT, ADDR_HOLD_TIME, ADDR_IRQ_MASK};
    logic [31:0] rv [5] = '{32'h0, 32'h64, 32'h190, 32'h14, 32'h0};
    logic [1:0] sel [4] = '{2'h0, 2'h1, 2'h3, 2'h2};
    int fast [4] = '{SLOW / 8, SLOW / 16, SLOW / 64, 0};

    swr_top #(.HOLD_RST(32'(HOLD)), .BASIC_RST(32'h64), .SLOW_RST(32'(SLOW))) dut (
        .REF_CLK_IN(clk), .RST_IN(rst), .WDOG_KICK_IN(kick), .MANUAL_RESET_N_IN(mr_n),
        .SUPPLY_UV_IN(uv), .AUX_UV_IN(aux), .WDOG_RANGE_SEL_IN(rng), .WINDOW_SEL_LO_IN(slo),
        .WINDOW_SEL_HI_IN(shi), .SUPERVISOR_OUT_N_OUT(out_n), .IRQ_OUT(irq),
        .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awvalid), .S_AXI_AWREADY_OUT(awready),
        .S_AXI_WDATA_IN(wdata), .S_AXI_WSTRB_IN(wstrb), .S_AXI_WVALID_IN(wvalid),
        .S_AXI_WREADY_OUT(wready), .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
        .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr), .S_AXI_ARVALID_IN(arvalid),
        .S_AXI_ARREADY_OUT(arready), .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
        .S_AXI_RVALID_OUT(rvalid), .S_AXI_RREADY_IN(rready));
    swr_cpu_model cpu (.clk_in(clk), .reset_n_in(out_n), .en_in(en), .period_in(per), .kick_out(kick));

    always #10 clk = ~clk;
    always @(posedge clk) low_cnt <= low_cnt + int'(out_n === 1'h0);

    // ========================================================
    // checking and closing
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task results;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : results

    task automatic hang(input int k, input int lim);
        if (k >= lim) begin
            chk(32'h0, 32'h1, "wait timed out");
            results();
        end
    endtask : hang

    // ========================================================
    // bus cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
        int k;
        @(posedge clk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (awready) awvalid <= 1'h0;
            if (wready) wvalid <= 1'h0;
            if (bvalid) break;
        end
        bready <= 1'h0;
        hang(k, 50);
        chk({30'h0, bresp}, {30'h0, er}, "write response");
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
        int k;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'h1;
        rready <= 1'h1;
        for (k = 0; k < 50; k++) begin
            @(posedge clk);
            if (arready) arvalid <= 1'h0;
            if (rvalid) break;
        end
        rready <= 1'h0;
        v = rdata;
        rr = rresp;
        hang(k, 50);
    endtask : rd

    task automatic rdc(input logic [7:0] a, input logic [31:0] ev, input logic [1:0] er);
        logic [31:0] v;
        logic [1:0] rr;
        rd(a, v, rr);
        chk(v, ev, "read data");
        chk({30'h0, rr}, {30'h0, er}, "read response");
    endtask : rdc

    // ========================================================
    // reset line watching
    task automatic wait_out(input logic v, input int lim);
        for (n = 0; n < lim; n++) begin
            @(posedge clk);
            if (out_n === v) return;
        end
        hang(n, lim);
    endtask : wait_out

    task automatic quiet(input int c, input string m);
        int base;
        base = low_cnt;
        repeat (c) @(posedge clk);
        chk(32'(low_cnt - base), 32'h0, m);
    endtask : quiet

    // ========================================================
    // main sequence
    initial begin
        clk = 1'h0;
        low_cnt = 0;
        {rst, mr_n, en, uv, aux, rng, slo, shi, awvalid, wvalid, bready, arvalid, rready} = 13'h1c00;
        {awaddr, araddr, wdata} = '0;
        wstrb = 4'hf;
        per = 16'h32;
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        foreach (ra[i]) rdc(ra[i], rv[i], RESP_OKAY);
        rdc(8'h20, 32'h0, RESP_SLVERR);
        wr(8'h20, 32'h1, RESP_SLVERR);
        wr(ADDR_STATE, 32'h0, RESP_OKAY);
        wait_out(1'h1, 60);
        rdc(ADDR_STATE, 32'h3, RESP_OKAY);
        // manual, supply and aux conditions; the last one runs with the interrupt masked
        for (int i = 0; i < 3; i++) begin
            wr(ADDR_IRQ_MASK, (i == 2) ? 32'h0 : 32'h8, RESP_OKAY);
            {mr_n, uv, aux} <= (i == 0) ? 3'h0 : (i == 1) ? 3'h6 : 3'h5;
            wait_out(1'h0, 8);
            chk(32'(n <= 4), 32'h1, "assert delay");
            repeat (4) @(posedge clk);
            {mr_n, uv, aux} <= 3'h4;
            wait_out(1'h1, 40);
            chk(32'(n >= HOLD && n <= HOLD + 4), 32'h1, "hold time");
            chk({31'h0, irq}, (i == 2) ? 32'h0 : 32'h1, "irq level");
            wr(ADDR_IRQ_STATUS, 32'hf, RESP_OKAY);
            rdc(ADDR_IRQ_STATUS, 32'h0, RESP_OKAY);
        end
        quiet(600, "kicked in time");
        en <= 1'h0;
        wait_out(1'h0, 130);
        chk(32'(n >= 45 && n <= 106), 32'h1, "basic timeout");
        wait_out(1'h1, 40);
        chk(32'(n >= HOLD - 2 && n <= HOLD + 2), 32'h1, "fault pulse");
        rd(ADDR_IRQ_STATUS, d, r);
        chk(d & 32'h7, 32'h1, "basic flag");
        wr(ADDR_IRQ_STATUS, 32'hf, RESP_OKAY);
        wr(ADDR_BASIC_PERIOD, 32'h0, RESP_OKAY);
        quiet(400, "basic disabled");
        rdc(ADDR_WD_COUNT, 32'h0, RESP_OKAY);
        rng <= 1'h1;
        repeat (4) @(posedge clk);
        wr(ADDR_BASIC_PERIOD, 32'h14, RESP_OKAY);
        wait_out(1'h0, 2700);
        chk(32'(n >= 2530 && n <= 2570), 32'h1, "extended timeout");
        wait_out(1'h1, 40);
        wr(ADDR_BASIC_PERIOD, 32'h64, RESP_OKAY);
        rng <= 1'h0;
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        // strap table: three ratios, then the disabled setting with no kicks at all
        for (int i = 0; i < 4; i++) begin
            en <= 1'h0;
            {slo, shi} <= sel[i];
            per <= 16'(2 * fast[i] + 4);
            repeat (4) @(posedge clk);
            en <= (i < 3);
            quiet(500, "window kept");
            if (i < 3) begin
                per <= 16'(fast[i] / 2);
                wait_out(1'h0, 300);
                en <= 1'h0;
                wait_out(1'h1, 40);
                wait_out(1'h0, 450);
                chk(32'(n >= 396 && n <= 406), 32'h1, "late fault");
                wait_out(1'h1, 40);
                rd(ADDR_IRQ_STATUS, d, r);
                chk(d & 32'h6, 32'h6, "early and late flags");
                wr(ADDR_IRQ_STATUS, 32'hf, RESP_OKAY);
            end
        end
        results();
    end
endmodule : tb
